// File: sdpb_cfg.svh
/*
 Constants of the servo drive parameter bank: register byte offsets,
 configuration bit positions, reset values and timing figures.
 Assumes it is included by its bare name from every file that needs it.
*/
`ifndef SDPB_CFG_SVH
`define SDPB_CFG_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SDPB_OFS_B_PHASE_CURRENT_OFFSET   8'h00
`define SDPB_OFS_C_PHASE_CURRENT_OFFSET   8'h04
`define SDPB_OFS_C_PHASE_CURRENT_SAMPLE   8'h08
`define SDPB_OFS_B_PHASE_CURRENT_SAMPLE   8'h0c
`define SDPB_OFS_BUS_CAP_VOLTAGE_SAMPLE   8'h10
`define SDPB_OFS_MOTOR_TEMP_SAMPLE        8'h14
`define SDPB_OFS_TIME_SINCE_RESTORE       8'h18
`define SDPB_OFS_DRIVE_IDENTITY_WORD      8'h1c
`define SDPB_OFS_DRIVE_IDENTITY_WORD_TWO  8'h20
`define SDPB_OFS_MULTIFUNCTION_CFG_ONE    8'h24
`define SDPB_OFS_MULTIFUNCTION_CFG_TWO    8'h28
`define SDPB_OFS_UNDERVOLT_THRESHOLD      8'h2c
`define SDPB_OFS_PASSWORD                 8'h30

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SDPB_RST_CFG_ONE            16'h00dc
`define SDPB_RST_CFG_TWO            16'h0002
`define SDPB_RST_OFFSET             16'h0000
`define SDPB_RST_UNDERVOLT          16'h4000
// Identity words and password key: arbitrary values
`define SDPB_IDENTITY_ONE           16'h0a5a
`define SDPB_IDENTITY_TWO           16'h05a5
`define SDPB_PASSWORD_KEY           16'h1234

// ----------------------------------------------------------------------------
// Bit positions of the multi-function words
// ----------------------------------------------------------------------------
`define SDPB_C1_AI_AUTO_CORRECT     0
`define SDPB_C1_DO_PROTECT_OFF      1
`define SDPB_C1_HOMING_NO_OFFSET    9
`define SDPB_C1_UNDERVOLT_RELAY     11
`define SDPB_C2_TFF_FROM_VELOCITY   0
`define SDPB_C2_TFF_DISABLE         1
`define SDPB_C2_PHASE_FIND_ON_PWR   2
`define SDPB_C2_LEARN_VF_ONLY       3
`define SDPB_C2_RESOLVER_RESOLVER_FREQUENCY_SELECT_ONE  4
`define SDPB_C2_RESOLVER_AUX_CTRL   5
`define SDPB_C2_RESOLVER_AUTO_CLR   6
`define SDPB_C2_PULSE_HIGH_SPEED    7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SDPB_CLK_PERIOD_PS          4000
`define SDPB_RUNTIME_UNIT_MS        1
`define SDPB_CYCLES_PER_MS          ((`SDPB_RUNTIME_UNIT_MS * 1000000000) / `SDPB_CLK_PERIOD_PS)
`define SDPB_CAL_LOG2_SAMPLES       4

`endif

// File: sdpb_pkg.sv
/*
 Types of the servo drive parameter bank.
 Assumes sdpb_cfg.svh is on the include path.
*/
package sdpb_pkg;

   // -------------------------------------------------------------------------
   // ADC sample bundle, one word per monitored channel
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] c_phase_current;
      logic [15:0] b_phase_current;
      logic [15:0] bus_cap_voltage;
      logic [15:0] motor_temp;
   } sdpb_adc_t;

   // -------------------------------------------------------------------------
   // Steering levels handed to the drive core
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic ai_auto_correct_en;
      logic do_protect_en;
      logic homing_no_offset;
      logic tff_from_velocity;
      logic tff_enable;
      logic encoder_learn_vf_only;
      logic resolver_frequency_select_one;
      logic resolver_aux_control;
      logic pulse_src_high_speed;
   } sdpb_ctrl_t;

   // Read answer: data and response code
   typedef struct packed {
      logic [31:0] data;
      logic [1:0]  resp;
   } sdpb_rd_t;

endpackage : sdpb_pkg

// File: sdpb_runtime_ms.sv
/*
 Millisecond running-time counter with its own cycle prescaler.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module sdpb_runtime_ms #(
   parameter int CYCLES_PER_MS = 250000
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // Control
   input  wire logic        i_run,
   input  wire logic        i_restore,
   // Count
   output logic [31:0]      o_ms_count
);

   logic [31:0] presc_r;
   logic [31:0] ms_count_r;

   // ---------------------------------------------------------------------------
   // Prescaler and counter
   // ---------------------------------------------------------------------------
   // Restore wins over counting so the count starts afresh at zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || i_restore) begin
         presc_r    <= 32'h0000_0000;
         ms_count_r <= 32'h0000_0000;
      end else if (i_run) begin
         if (presc_r == 32'(CYCLES_PER_MS - 1)) begin
            presc_r    <= 32'h0000_0000;
            ms_count_r <= ms_count_r + 32'h0000_0001;
         end else begin
            presc_r <= presc_r + 32'h0000_0001;
         end
      end
   end

   assign o_ms_count = ms_count_r;

endmodule : sdpb_runtime_ms

// File: sdpb_param_bank.sv
/*
 Servo drive parameter bank: monitor, identity and multi-function
 configuration registers behind an AXI4-Lite slave, plus the steering
 levels those registers drive into the drive core.
 Assumes ADC samples arrive synchronous to i_ref_clk with a valid strobe,
 and that the drive core acts on the steering levels it is given.
*/
// Decided for this implementation: the address map and the AXI4-Lite register port.
// Behaviour
// - Bit 0 of the first configuration word turns on analog input offset correction.
// - Bit 1 of the first configuration word turns digital output protection off.
// - With bit 11 of the first word set the relay opens on undervoltage, with it clear a closed relay stays closed.
// - Bit 9 of the first word makes homing take the found origin directly as offset position.
// - Bit 0 of the second word picks velocity-based torque feedforward when one, position-based when zero.
// - Bit 1 of the second word disables torque feedforward while the loop-structure selector is 0 or 1.
// - Bit 2 of the second word starts linear-motor phase finding once after power-on.
// - Bit 3 of the second word makes encoder learning skip parameter learning and run open-loop V/f only.
// - Bit 4 of the second word asserts the resolver frequency-select-one setting.
// - Bit 5 of the second word asserts the auxiliary resolver control setting.
// - Bit 6 of the second word clears resolver faults automatically.
// - Bit 7 of the second word selects the high-speed pulse input, zero the low-speed one.
// - The C-phase offset is password protected and computed at every power-on.
`timescale 1ns/1ns
`include "sdpb_cfg.svh"
module sdpb_param_bank #(
   parameter int CYCLES_PER_MS = `SDPB_CYCLES_PER_MS
) (
   // Clock and reset
   input  wire logic                i_ref_clk,
   input  wire logic                i_resetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]          i_s_axi_awaddr,
   input  wire logic                i_s_axi_awvalid,
   output logic                     o_s_axi_awready,
   input  wire logic [31:0]         i_s_axi_wdata,
   input  wire logic [3:0]          i_s_axi_wstrb,
   input  wire logic                i_s_axi_wvalid,
   output logic                     o_s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]               o_s_axi_bresp,
   output logic                     o_s_axi_bvalid,
   input  wire logic                i_s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]          i_s_axi_araddr,
   input  wire logic                i_s_axi_arvalid,
   output logic                     o_s_axi_arready,
   output logic [31:0]              o_s_axi_rdata,
   output logic [1:0]               o_s_axi_rresp,
   output logic                     o_s_axi_rvalid,
   input  wire logic                i_s_axi_rready,
   // Drive core inputs
   input  wire sdpb_pkg::sdpb_adc_t i_adc,
   input  wire logic                i_adc_valid,
   input  wire logic [3:0]          i_loop_structure_selector,
   input  wire logic                i_relay_close_req,
   input  wire logic                i_drive_run,
   input  wire logic                i_factory_restore,
   input  wire logic                i_resolver_fault,
   // Drive core outputs
   output sdpb_pkg::sdpb_ctrl_t     o_ctrl,
   output logic                     o_relay_close,
   output logic                     o_phase_find_start,
   output logic                     o_resolver_fault_clear
);
   import sdpb_pkg::*;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ---------------------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------------------
   logic [15:0] cfg_one_r;
   logic [15:0] cfg_two_r;
   logic [15:0] uv_threshold_r;
   logic        unlocked_r;
   logic [15:0] b_offset_r;
   logic [15:0] c_offset_r;
   sdpb_adc_t   adc_r;
   logic [31:0] ms_count;
   // Power-on offset calibration
   logic [`SDPB_CAL_LOG2_SAMPLES:0]      cal_cnt_r;
   logic [16+`SDPB_CAL_LOG2_SAMPLES-1:0] b_sum_r;
   logic [16+`SDPB_CAL_LOG2_SAMPLES-1:0] c_sum_r;
   logic        cal_done_r;
   logic        phase_find_pending_r;
   // Bus state
   logic        aw_hold_r;
   logic [7:0]  aw_addr_r;
   logic        w_hold_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        ar_hold_r;
   logic [7:0]  ar_addr_r;
   logic        do_write;
   logic        wr_ok;
   logic [15:0] wr_half;
   sdpb_rd_t    rd_nxt;

   // ---------------------------------------------------------------------------
   // Write address and data channels
   // ---------------------------------------------------------------------------
   // Address and data are accepted in either order, one write at a time
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_s_axi_awready <= 1'b0;
         aw_hold_r       <= 1'b0;
         aw_addr_r       <= 8'h00;
      end else if (i_s_axi_awvalid && o_s_axi_awready) begin
         o_s_axi_awready <= 1'b0;
         aw_hold_r       <= 1'b1;
         aw_addr_r       <= i_s_axi_awaddr;
      end else if (do_write) begin
         aw_hold_r <= 1'b0;
      end else if (!aw_hold_r && !o_s_axi_bvalid) begin
         o_s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_s_axi_wready <= 1'b0;
         w_hold_r       <= 1'b0;
         w_data_r       <= 32'h0000_0000;
         w_strb_r       <= 4'h0;
      end else if (i_s_axi_wvalid && o_s_axi_wready) begin
         o_s_axi_wready <= 1'b0;
         w_hold_r       <= 1'b1;
         w_data_r       <= i_s_axi_wdata;
         w_strb_r       <= i_s_axi_wstrb;
      end else if (do_write) begin
         w_hold_r <= 1'b0;
      end else if (!w_hold_r && !o_s_axi_bvalid) begin
         o_s_axi_wready <= 1'b1;
      end
   end

   assign do_write = aw_hold_r && w_hold_r && !o_s_axi_bvalid;

   // Low half of the write word with byte strobes applied per register
   function automatic logic [15:0] merge_half(input logic [15:0] old_v);
      merge_half[7:0]  = w_strb_r[0] ? w_data_r[7:0]  : old_v[7:0];
      merge_half[15:8] = w_strb_r[1] ? w_data_r[15:8] : old_v[15:8];
   endfunction : merge_half

   assign wr_half = w_data_r[15:0];

   // ---------------------------------------------------------------------------
   // Write response
   // ---------------------------------------------------------------------------
   // Read-only registers answer OKAY and keep their contents
   always_comb begin
      wr_ok = 1'b1;
      unique case (aw_addr_r)
         `SDPB_OFS_B_PHASE_CURRENT_OFFSET,
         `SDPB_OFS_C_PHASE_CURRENT_OFFSET:  wr_ok = unlocked_r;
         `SDPB_OFS_C_PHASE_CURRENT_SAMPLE,
         `SDPB_OFS_B_PHASE_CURRENT_SAMPLE,
         `SDPB_OFS_BUS_CAP_VOLTAGE_SAMPLE,
         `SDPB_OFS_MOTOR_TEMP_SAMPLE,
         `SDPB_OFS_TIME_SINCE_RESTORE,
         `SDPB_OFS_DRIVE_IDENTITY_WORD,
         `SDPB_OFS_DRIVE_IDENTITY_WORD_TWO,
         `SDPB_OFS_MULTIFUNCTION_CFG_ONE,
         `SDPB_OFS_MULTIFUNCTION_CFG_TWO,
         `SDPB_OFS_UNDERVOLT_THRESHOLD,
         `SDPB_OFS_PASSWORD:                wr_ok = 1'b1;
         default:                           wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         o_s_axi_bvalid <= 1'b1;
         if (wr_ok) begin
            o_s_axi_bresp <= RESP_OKAY;
         end else if (aw_addr_r == `SDPB_OFS_B_PHASE_CURRENT_OFFSET ||
                      aw_addr_r == `SDPB_OFS_C_PHASE_CURRENT_OFFSET) begin
            o_s_axi_bresp <= RESP_SLVERR;
         end else begin
            o_s_axi_bresp <= RESP_DECERR;
         end
      end else if (i_s_axi_bready) begin
         o_s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Writable registers
   // ---------------------------------------------------------------------------
   // All sixteen bits are kept, undefined ones steer nothing
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         cfg_one_r      <= `SDPB_RST_CFG_ONE;
         cfg_two_r      <= `SDPB_RST_CFG_TWO;
         uv_threshold_r <= `SDPB_RST_UNDERVOLT;
      end else if (do_write) begin
         if (aw_addr_r == `SDPB_OFS_MULTIFUNCTION_CFG_ONE) begin
            cfg_one_r <= merge_half(cfg_one_r);
         end
         if (aw_addr_r == `SDPB_OFS_MULTIFUNCTION_CFG_TWO) begin
            cfg_two_r <= merge_half(cfg_two_r);
         end
         if (aw_addr_r == `SDPB_OFS_UNDERVOLT_THRESHOLD) begin
            uv_threshold_r <= merge_half(uv_threshold_r);
         end
      end
   end

   // Any write to the password word locks again unless it carries the key
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         unlocked_r <= 1'b0;
      end else if (do_write && aw_addr_r == `SDPB_OFS_PASSWORD) begin
         unlocked_r <= (wr_half == `SDPB_PASSWORD_KEY);
      end
   end

   // ---------------------------------------------------------------------------
   // Monitors and power-on offset calibration
   // ---------------------------------------------------------------------------
   // Samples only ever come from the ADC side, never from the bus
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         adc_r <= '0;
      end else if (i_adc_valid) begin
         adc_r <= i_adc;
      end
   end

   // Offsets are the sum of the first 15 samples after reset divided by 16, motor at rest
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         cal_cnt_r  <= '0;
         b_sum_r    <= '0;
         c_sum_r    <= '0;
         cal_done_r <= 1'b0;
         b_offset_r <= `SDPB_RST_OFFSET;
         c_offset_r <= `SDPB_RST_OFFSET;
      end else if (!cal_done_r && i_adc_valid) begin
         b_sum_r   <= b_sum_r + {{`SDPB_CAL_LOG2_SAMPLES{1'b0}}, i_adc.b_phase_current};
         c_sum_r   <= c_sum_r + {{`SDPB_CAL_LOG2_SAMPLES{1'b0}}, i_adc.c_phase_current};
         cal_cnt_r <= cal_cnt_r + 1'b1;
         if (cal_cnt_r[`SDPB_CAL_LOG2_SAMPLES-1:0] == {`SDPB_CAL_LOG2_SAMPLES{1'b1}}) begin
            cal_done_r <= 1'b1;
            b_offset_r <= b_sum_r[16+`SDPB_CAL_LOG2_SAMPLES-1:`SDPB_CAL_LOG2_SAMPLES];
            c_offset_r <= c_sum_r[16+`SDPB_CAL_LOG2_SAMPLES-1:`SDPB_CAL_LOG2_SAMPLES];
         end
      end
   end

   // Running-time counter
   sdpb_runtime_ms #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_runtime (
      .i_ref_clk  (i_ref_clk),
      .i_resetn   (i_resetn),
      .i_run      (i_drive_run),
      .i_restore  (i_factory_restore),
      .o_ms_count (ms_count)
   );

   // ---------------------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------------------
   // Protected offsets read zero with SLVERR until the password is given
   always_comb begin
      rd_nxt = '{data: 32'h0000_0000, resp: RESP_OKAY};
      unique case (ar_addr_r)
         `SDPB_OFS_B_PHASE_CURRENT_OFFSET: begin
            if (unlocked_r) rd_nxt.data = {16'h0000, b_offset_r};
            else            rd_nxt.resp = RESP_SLVERR;
         end
         `SDPB_OFS_C_PHASE_CURRENT_OFFSET: begin
            if (unlocked_r) rd_nxt.data = {16'h0000, c_offset_r};
            else            rd_nxt.resp = RESP_SLVERR;
         end
         `SDPB_OFS_C_PHASE_CURRENT_SAMPLE:   rd_nxt.data = {16'h0000, adc_r.c_phase_current};
         `SDPB_OFS_B_PHASE_CURRENT_SAMPLE:   rd_nxt.data = {16'h0000, adc_r.b_phase_current};
         `SDPB_OFS_BUS_CAP_VOLTAGE_SAMPLE:   rd_nxt.data = {16'h0000, adc_r.bus_cap_voltage};
         `SDPB_OFS_MOTOR_TEMP_SAMPLE:        rd_nxt.data = {16'h0000, adc_r.motor_temp};
         `SDPB_OFS_TIME_SINCE_RESTORE:       rd_nxt.data = ms_count;
         `SDPB_OFS_DRIVE_IDENTITY_WORD:      rd_nxt.data = {16'h0000, 16'(`SDPB_IDENTITY_ONE)};
         `SDPB_OFS_DRIVE_IDENTITY_WORD_TWO:  rd_nxt.data = {16'h0000, 16'(`SDPB_IDENTITY_TWO)};
         `SDPB_OFS_MULTIFUNCTION_CFG_ONE:    rd_nxt.data = {16'h0000, cfg_one_r};
         `SDPB_OFS_MULTIFUNCTION_CFG_TWO:    rd_nxt.data = {16'h0000, cfg_two_r};
         `SDPB_OFS_UNDERVOLT_THRESHOLD:      rd_nxt.data = {16'h0000, uv_threshold_r};
         `SDPB_OFS_PASSWORD:                 rd_nxt.data = {31'h0000_0000, unlocked_r};
         default:                            rd_nxt.resp = RESP_DECERR;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_s_axi_arready <= 1'b0;
         ar_hold_r       <= 1'b0;
         ar_addr_r       <= 8'h00;
         o_s_axi_rvalid  <= 1'b0;
         o_s_axi_rdata   <= 32'h0000_0000;
         o_s_axi_rresp   <= RESP_OKAY;
      end else begin
         if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_arready <= 1'b0;
            ar_hold_r       <= 1'b1;
            ar_addr_r       <= i_s_axi_araddr;
         end else if (ar_hold_r && !o_s_axi_rvalid) begin
            ar_hold_r      <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rd_nxt.data;
            o_s_axi_rresp  <= rd_nxt.resp;
         end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
         end else if (!ar_hold_r && !o_s_axi_rvalid) begin
            o_s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Steering levels
   // ---------------------------------------------------------------------------
   // Registered so every output leaves from a flip-flop, one cycle after a write
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_ctrl <= '0;
      end else begin
         o_ctrl.ai_auto_correct_en            <= cfg_one_r[`SDPB_C1_AI_AUTO_CORRECT];
         o_ctrl.do_protect_en                 <= !cfg_one_r[`SDPB_C1_DO_PROTECT_OFF];
         o_ctrl.homing_no_offset              <= cfg_one_r[`SDPB_C1_HOMING_NO_OFFSET];
         o_ctrl.tff_from_velocity             <= cfg_two_r[`SDPB_C2_TFF_FROM_VELOCITY];
         o_ctrl.tff_enable                    <= !(cfg_two_r[`SDPB_C2_TFF_DISABLE] &&
                                                   i_loop_structure_selector <= 4'h1);
         o_ctrl.encoder_learn_vf_only         <= cfg_two_r[`SDPB_C2_LEARN_VF_ONLY];
         o_ctrl.resolver_frequency_select_one <= cfg_two_r[`SDPB_C2_RESOLVER_RESOLVER_FREQUENCY_SELECT_ONE];
         o_ctrl.resolver_aux_control          <= cfg_two_r[`SDPB_C2_RESOLVER_AUX_CTRL];
         o_ctrl.pulse_src_high_speed          <= cfg_two_r[`SDPB_C2_PULSE_HIGH_SPEED];
      end
   end

   // Relay: opens on undervoltage only when enabled, otherwise latches closed
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_relay_close <= 1'b0;
      end else if (cfg_one_r[`SDPB_C1_UNDERVOLT_RELAY]) begin
         o_relay_close <= i_relay_close_req && (adc_r.bus_cap_voltage >= uv_threshold_r);
      end else begin
         o_relay_close <= o_relay_close || i_relay_close_req;
      end
   end

   // Phase finding fires once per power-on, before the first run
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         phase_find_pending_r <= 1'b1;
         o_phase_find_start   <= 1'b0;
      end else begin
         o_phase_find_start <= 1'b0;
         if (phase_find_pending_r && cal_done_r && cfg_two_r[`SDPB_C2_PHASE_FIND_ON_PWR]) begin
            o_phase_find_start   <= 1'b1;
            phase_find_pending_r <= 1'b0;
         end else if (i_drive_run) begin
            phase_find_pending_r <= 1'b0;
         end
      end
   end

   // Fault clear follows the fault level while auto clearing is on
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_resolver_fault_clear <= 1'b0;
      end else begin
         o_resolver_fault_clear <= i_resolver_fault && cfg_two_r[`SDPB_C2_RESOLVER_AUTO_CLR];
      end
   end

endmodule : sdpb_param_bank

// File: sdpb_param_bank_props.sv
/* Checker for the parameter bank: bus answers and steering levels.
   Assumes one clock and sync active-low reset; bound below. */
`timescale 1ns/1ns
module sdpb_param_bank_props (
   // Bus and reset, grouped to keep the file short
   input wire logic i_ref_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid,
   input wire logic i_s_axi_rready, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid,
   input wire logic [7:0] i_s_axi_awaddr, i_s_axi_araddr,
   input wire logic [31:0] i_s_axi_wdata, o_s_axi_rdata,
   input wire logic [3:0] i_s_axi_wstrb, i_loop_structure_selector,
   input wire logic [1:0] o_s_axi_bresp, o_s_axi_rresp,
   // Drive core side
   input wire logic i_resolver_fault, o_resolver_fault_clear,
   input wire sdpb_pkg::sdpb_ctrl_t o_ctrl
);
   import sdpb_pkg::*;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // Both halves of a write taken at one edge
   sequence s_wr_take; i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready; endsequence
   sequence s_ar_take; i_s_axi_arvalid && o_s_axi_arready; endsequence
   property p_wr_resp; s_wr_take |-> ##2 o_s_axi_bvalid; endproperty
   property p_rd_dec; s_ar_take ##0 i_s_axi_araddr > 8'h33 |-> ##2 o_s_axi_rvalid && o_s_axi_rresp == 2'h3; endproperty
   property p_b_stand; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp); endproperty
   property p_r_stand; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata); endproperty
   // Register lands with the response, steering one edge later
   property p_cfg_one; logic [15:0] d;
      (s_wr_take ##0 (i_s_axi_awaddr == 8'h24 && i_s_axi_wstrb[1:0] == 2'b11), d = i_s_axi_wdata[15:0]) |-> ##3
      (o_ctrl.ai_auto_correct_en == d[0] && o_ctrl.do_protect_en == !d[1] && o_ctrl.homing_no_offset == d[9]);
   endproperty
   property p_cfg_two; logic [15:0] d;
      (s_wr_take ##0 (i_s_axi_awaddr == 8'h28 && i_s_axi_wstrb[1:0] == 2'b11), d = i_s_axi_wdata[15:0]) |-> ##3
      (o_ctrl.tff_from_velocity == d[0] && o_ctrl.encoder_learn_vf_only == d[3] &&
       o_ctrl.resolver_frequency_select_one == d[4] && o_ctrl.resolver_aux_control == d[5] &&
       o_ctrl.pulse_src_high_speed == d[7]);
   endproperty
   property p_tff; (i_loop_structure_selector > 4'h1) [*3] |-> o_ctrl.tff_enable; endproperty
   property p_fclr; o_resolver_fault_clear |-> $past(i_resolver_fault); endproperty
   a_wr_resp : assert property (p_wr_resp) else $error("no write response");
   a_rd_dec : assert property (p_rd_dec) else $error("unmapped read not refused");
   a_b_stand : assert property (p_b_stand) else $error("write response dropped");
   a_r_stand : assert property (p_r_stand) else $error("read data dropped");
   a_cfg_one : assert property (p_cfg_one) else $error("first word steering wrong");
   a_cfg_two : assert property (p_cfg_two) else $error("second word steering wrong");
   a_tff : assert property (p_tff) else $error("feedforward off outside selector 0/1");
   a_fclr : assert property (p_fclr) else $error("fault clear without fault");
endmodule : sdpb_param_bank_props
bind sdpb_param_bank sdpb_param_bank_props i_props (.i_ref_clk, .i_resetn, .i_s_axi_awvalid, .i_s_axi_wvalid,
   .i_s_axi_bready, .i_s_axi_arvalid, .i_s_axi_rready, .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid,
   .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_awaddr, .i_s_axi_araddr, .i_s_axi_wdata, .o_s_axi_rdata,
   .i_s_axi_wstrb, .i_loop_structure_selector, .o_s_axi_bresp, .o_s_axi_rresp, .i_resolver_fault,
   .o_resolver_fault_clear, .o_ctrl);

// File: sdpb_param_bank_tb_top.sv
/* Bench for the parameter bank over its register bus.
   Assumes constant phase-current samples, so offsets are fixed fractions of them. */
`timescale 1ns/1ns
module sdpb_param_bank_tb_top;
   import sdpb_pkg::*;
   logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, run = 1, rest = 0, flt = 1;
   logic awr, wrd, bv, arr, rv, rel, fclr;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdt;
   logic [3:0] sel = 0;
   logic [1:0] br, rr, r;
   logic [33:0] v;
   sdpb_ctrl_t ctrl;
   sdpb_adc_t adc = {16'h0200, 16'h0100, 16'h5000, 16'h0010};
   int bad_count = 0, compares = 0;
   // Short ms prescale keeps the run brief
   sdpb_param_bank #(.CYCLES_PER_MS(4)) i_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_s_axi_awaddr(awa),
      .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
      .o_s_axi_wready(wrd), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre), .i_s_axi_araddr(ara),
      .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rdt), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv),
      .i_s_axi_rready(rre), .i_adc(adc), .i_adc_valid(1'b1), .i_loop_structure_selector(sel),
      .i_relay_close_req(1'b1), .i_drive_run(run), .i_factory_restore(rest), .i_resolver_fault(flt),
      .o_ctrl(ctrl), .o_relay_close(rel), .o_phase_find_start(), .o_resolver_fault_clear(fclr));
   initial forever #2 clk = ~clk;
   task chk(input logic [33:0] got, input logic [33:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Each channel released at its own handshake
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk); awa <= a; wd <= d; awv <= 1; wv <= 1;
      do begin @(posedge clk); if (awr) awv <= 0; if (wrd) wv <= 0; end while (!bv);
      bre <= 1; @(posedge clk); r = br; bre <= 0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk); ara <= a; arv <= 1;
      do begin @(posedge clk); if (arr) arv <= 0; end while (!rv);
      rre <= 1; @(posedge clk); v = {rr, rdt}; rre <= 0;
   endtask : rd
   task wrap_up;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clk); rstn <= 1; repeat (30) @(posedge clk);
      rd(8'h24); chk(v, 34'hdc);
      rd(8'h28); chk(v, 34'h2);
      rd(8'h00); chk(v, {2'b10, 32'h0});
      rd(8'h04); chk(v, {2'b10, 32'h0});
      rd(8'h40); chk(34'(v[33:32]), 34'h3);
      wr(8'h1c, 32'hffff); chk(34'(r), 34'h0);
      rd(8'h1c); chk(v, 34'h0a5a);
      rd(8'h0c); chk(v, 34'h100);
      chk(34'(rel), 34'h1);
      wr(8'h28, 32'hff); rd(8'h28); chk(v, 34'hff);
      chk(34'(ctrl), 34'h0af);
      chk(34'(fclr), 34'h1);
      adc.bus_cap_voltage <= 16'h1000; sel <= 4'h2;
      wr(8'h24, 32'h0a03); repeat (3) @(posedge clk);
      chk(34'(ctrl), 34'h17f);
      chk(34'(rel), 34'h0);
      wr(8'h28, 32'hff00); rd(8'h28); chk(v, 34'hff00);
      chk(34'(ctrl), 34'h150);
      chk(34'(fclr), 34'h0);
      wr(8'h30, 32'h1234); rd(8'h00); chk(v, 34'hf0);
      rd(8'h04); chk(v, 34'h1e0);
      rd(8'h18); chk(34'(v[31:0] != 0), 34'h1);
      rest <= 1; run <= 0; repeat (3) @(posedge clk); rest <= 0;
      rd(8'h18); chk(v, 34'h0);
      wrap_up;
   end
endmodule : sdpb_param_bank_tb_top
